/* File: verilog/eit_core.sv */
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
// ********************************************************************
// External interrupt and timer input block
// ********************************************************************
module eit_core #(
   parameter int TICK_DIV = eit_pkg::TICK_DIV
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Avalon-MM slave.
   input wire logic [eit_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [eit_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [eit_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Pins.
   input wire logic ext_irq_a_pin_i,
   input wire logic ext_irq_b_pin_i,
   input wire logic timer_a_count_pin_i,
   input wire logic timer_b_count_pin_i,
   input wire logic usb_wake_event_i,
   // Status to the rest of the device.
   output logic ext_irq_a_pending_o,
   output logic ext_irq_b_pending_o,
   output logic cpu_halt_o,
   output logic periph_clk_en_o,
   output logic irq_o
);
   // ********************************************************************
   // Declarations
   // ********************************************************************
   logic [4:0] pin_level;
   logic [4:0] pin_fall;
   logic [eit_pkg::CTRL_W-1:0] timer_control_reg;
   logic ext_irq_a_pending_reg;
   logic ext_irq_b_pending_reg;
   logic idle_reg;
   logic pdown_reg;
   logic [eit_pkg::CNT_W-1:0] timer_a_reg;
   logic [eit_pkg::CNT_W-1:0] timer_b_reg;
   logic [eit_pkg::EV_W-1:0] irq_status_reg;
   logic [eit_pkg::EV_W-1:0] irq_enable_reg;
   logic [eit_pkg::EV_W-1:0] events;
   logic ack_reg;
   logic [eit_pkg::DATA_W-1:0] readdata_reg;
   logic [7:0] tick_cnt_reg;
   logic tick;
   logic req;
   logic wr_take;
   logic rd_load;
   logic [eit_pkg::DATA_W-1:0] rd_mux;
   logic periph_run;
   logic a_step;
   logic b_step;
   logic a_ovf;
   logic b_ovf;
   logic a_pend_prev_reg;
   logic b_pend_prev_reg;
   logic wake;

   localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

   // Merges write data into a word under the byte enables.
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] be);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            res[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // Decides whether one timer advances in this cycle.
   function automatic logic timer_step(input logic run, input logic gate,
                                       input logic gate_pin, input logic cnt_mode,
                                       input logic pin_fall_ev, input logic tck);
      logic enabled;
      enabled = run && (!gate || gate_pin);
      return enabled && (cnt_mode ? pin_fall_ev : tck);
   endfunction : timer_step

   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   // The USB wake line is treated as asynchronous too, since it comes from
   // the bus clock side of the device.
   eit_pin_sync #(
      .W(5)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .pin_i({usb_wake_event_i, timer_b_count_pin_i, timer_a_count_pin_i,
              ext_irq_b_pin_i, ext_irq_a_pin_i}),
      .level_o(pin_level),
      .fall_o(pin_fall)
   );

   // ********************************************************************
   // Bus slave
   // ********************************************************************
   // One wait cycle: the request is seen, read data is loaded, then
   // waitrequest drops and the access completes at that edge.
   assign req = (avs_read_i || avs_write_i);
   assign avs_waitrequest_o = req && !ack_reg;
   assign wr_take = avs_write_i && ack_reg;
   assign rd_load = avs_read_i && !ack_reg;

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         ack_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= req && !ack_reg;
      end
   end

   // Read multiplexer; unmapped and write-only words read as zero.
   always_comb
   begin
      rd_mux = '0;
      unique case (avs_address_i)
         eit_pkg::OFS_CTRL: rd_mux[eit_pkg::CTRL_W-1:0] = timer_control_reg;
         eit_pkg::OFS_PEND:
         begin
            rd_mux[eit_pkg::PEND_A] = ext_irq_a_pending_reg;
            rd_mux[eit_pkg::PEND_B] = ext_irq_b_pending_reg;
         end
         eit_pkg::OFS_POWER:
         begin
            rd_mux[eit_pkg::PWR_IDLE] = idle_reg;
            rd_mux[eit_pkg::PWR_DOWN] = pdown_reg;
         end
         eit_pkg::OFS_TIMER_A: rd_mux[eit_pkg::CNT_W-1:0] = timer_a_reg;
         eit_pkg::OFS_TIMER_B: rd_mux[eit_pkg::CNT_W-1:0] = timer_b_reg;
         eit_pkg::OFS_IRQ_STATUS: rd_mux[eit_pkg::EV_W-1:0] = irq_status_reg;
         eit_pkg::OFS_IRQ_ENABLE: rd_mux[eit_pkg::EV_W-1:0] = irq_enable_reg;
         default: rd_mux = '0;
      endcase
   end

   // Read data is captured in the wait cycle and held until the next read.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         readdata_reg <= '0;
      end
      else if (rd_load)
      begin
         readdata_reg <= rd_mux;
      end
   end
   assign avs_readdata_o = readdata_reg;

   // ********************************************************************
   // Control register
   // ********************************************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         timer_control_reg <= eit_pkg::CTRL_RESET;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_CTRL && avs_byteenable_i[0])
      begin
         timer_control_reg <= avs_writedata_i[eit_pkg::CTRL_W-1:0];
      end
   end

   // ********************************************************************
   // External interrupt pending flags
   // ********************************************************************
   // Software clears with a one; a pin event in the same cycle wins. In level
   // mode the flag is set again every cycle the pin stays low, so it cannot
   // be cleared until the pin is released.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         ext_irq_a_pending_reg <= 1'b0;
      end
      else if (timer_control_reg[eit_pkg::CTRL_A_EDGE] ? pin_fall[0] : !pin_level[0])
      begin
         ext_irq_a_pending_reg <= 1'b1;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_PEND && avs_byteenable_i[0]
               && avs_writedata_i[eit_pkg::PEND_A])
      begin
         ext_irq_a_pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         ext_irq_b_pending_reg <= 1'b0;
      end
      else if (timer_control_reg[eit_pkg::CTRL_B_EDGE] ? pin_fall[1] : !pin_level[1])
      begin
         ext_irq_b_pending_reg <= 1'b1;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_PEND && avs_byteenable_i[0]
               && avs_writedata_i[eit_pkg::PEND_B])
      begin
         ext_irq_b_pending_reg <= 1'b0;
      end
   end

   assign ext_irq_a_pending_o = ext_irq_a_pending_reg;
   assign ext_irq_b_pending_o = ext_irq_b_pending_reg;

   // ********************************************************************
   // Power modes
   // ********************************************************************
   // Pin detection keeps running on the core clock in power-down, so that
   // a pending flag can wake the device.
   assign wake = ext_irq_a_pending_reg || ext_irq_b_pending_reg || pin_fall[4];

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         pdown_reg <= 1'b0;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_POWER && avs_byteenable_i[0]
               && avs_writedata_i[eit_pkg::PWR_DOWN])
      begin
         pdown_reg <= 1'b1;
      end
      else if (wake)
      begin
         pdown_reg <= 1'b0;
      end
   end

   // Idle ends on any enabled interrupt or pending external request.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         idle_reg <= 1'b0;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_POWER && avs_byteenable_i[0]
               && avs_writedata_i[eit_pkg::PWR_IDLE])
      begin
         idle_reg <= 1'b1;
      end
      else if (irq_o || wake)
      begin
         idle_reg <= 1'b0;
      end
   end

   assign cpu_halt_o = idle_reg || pdown_reg;
   assign periph_run = !pdown_reg;
   assign periph_clk_en_o = periph_run;

   // ********************************************************************
   // Timers
   // ********************************************************************
   // Tick divider; frozen with the peripheral clock in power-down.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         tick_cnt_reg <= '0;
      end
      else if (periph_run)
      begin
         tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 8'h00 : tick_cnt_reg + 8'h01;
      end
   end
   assign tick = periph_run && (tick_cnt_reg == TICK_LAST);

   // Counter mode takes pin edges only while the peripheral clock runs.
   assign a_step = periph_run && timer_step(timer_control_reg[eit_pkg::CTRL_A_RUN],
      timer_control_reg[eit_pkg::CTRL_A_GATE], pin_level[0],
      timer_control_reg[eit_pkg::CTRL_A_CNT], pin_fall[2], tick);
   assign b_step = periph_run && timer_step(timer_control_reg[eit_pkg::CTRL_B_RUN],
      timer_control_reg[eit_pkg::CTRL_B_GATE], pin_level[1],
      timer_control_reg[eit_pkg::CTRL_B_CNT], pin_fall[3], tick);
   assign a_ovf = a_step && (timer_a_reg == '1);
   assign b_ovf = b_step && (timer_b_reg == '1);

   // A software write to a count wins over a step in the same cycle.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         timer_a_reg <= eit_pkg::TIMER_RESET;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_TIMER_A)
      begin
         timer_a_reg <= 16'(merge_bytes({16'h0000, timer_a_reg}, avs_writedata_i,
                                        avs_byteenable_i));
      end
      else if (a_step)
      begin
         timer_a_reg <= timer_a_reg + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         timer_b_reg <= eit_pkg::TIMER_RESET;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_TIMER_B)
      begin
         timer_b_reg <= 16'(merge_bytes({16'h0000, timer_b_reg}, avs_writedata_i,
                                        avs_byteenable_i));
      end
      else if (b_step)
      begin
         timer_b_reg <= timer_b_reg + 16'h0001;
      end
   end

   // ********************************************************************
   // Interrupt status, clear and enable
   // ********************************************************************
   // Pending events are rising edges of the flags, so a level-held pin
   // raises the status bit once rather than every cycle.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         a_pend_prev_reg <= 1'b0;
         b_pend_prev_reg <= 1'b0;
      end
      else
      begin
         a_pend_prev_reg <= ext_irq_a_pending_reg;
         b_pend_prev_reg <= ext_irq_b_pending_reg;
      end
   end

   always_comb
   begin
      events = '0;
      events[eit_pkg::EV_PEND_A] = ext_irq_a_pending_reg && !a_pend_prev_reg;
      events[eit_pkg::EV_PEND_B] = ext_irq_b_pending_reg && !b_pend_prev_reg;
      events[eit_pkg::EV_OVF_A] = a_ovf;
      events[eit_pkg::EV_OVF_B] = b_ovf;
      events[eit_pkg::EV_WAKE] = pdown_reg && wake;
   end

   // A new event in the clearing cycle keeps its bit set.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         irq_status_reg <= '0;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_IRQ_CLEAR && avs_byteenable_i[0])
      begin
         irq_status_reg <= (irq_status_reg & ~avs_writedata_i[eit_pkg::EV_W-1:0]) | events;
      end
      else
      begin
         irq_status_reg <= irq_status_reg | events;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         irq_enable_reg <= eit_pkg::IRQ_EN_RESET;
      end
      else if (wr_take && avs_address_i == eit_pkg::OFS_IRQ_ENABLE && avs_byteenable_i[0])
      begin
         irq_enable_reg <= avs_writedata_i[eit_pkg::EV_W-1:0];
      end
   end

   assign irq_o = |(irq_status_reg & irq_enable_reg);
endmodule : eit_core

/* File: verilog/eit_pkg.sv */
// Contract
// - Edge select set: first pin falling edge sets first pending flag.
// - Edge select clear: first pin low level keeps setting first pending flag.
// - Edge select set: second pin falling edge sets second pending flag.
// - Edge select clear: second pin low level keeps setting second pending flag.
// - Gate select on: timer A runs only while first interrupt pin is high.
// - Gate select on: timer B runs only while second interrupt pin is high.
// - Timer A in counter mode counts falling edges of its count pin.
// - Timer B in counter mode counts falling edges of its count pin.
// - Idle halts the core but timers and interrupt logic keep running.
// - Power-down stops the peripheral clock enable; stored state is kept.
// - Power-down is left on a USB wake event or an external interrupt.

`timescale 1ns/100ps

// ********************************************************************
// Shared constants
// ********************************************************************
package eit_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   // Byte addresses of the register words.
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_PEND = 6'h04;
   localparam logic [5:0] OFS_POWER = 6'h08;
   localparam logic [5:0] OFS_TIMER_A = 6'h0c;
   localparam logic [5:0] OFS_TIMER_B = 6'h10;
   localparam logic [5:0] OFS_IRQ_STATUS = 6'h14;
   localparam logic [5:0] OFS_IRQ_CLEAR = 6'h18;
   localparam logic [5:0] OFS_IRQ_ENABLE = 6'h1c;
   // Control word field positions.
   localparam int CTRL_A_EDGE = 0;
   localparam int CTRL_B_EDGE = 1;
   localparam int CTRL_A_GATE = 2;
   localparam int CTRL_B_GATE = 3;
   localparam int CTRL_A_RUN = 4;
   localparam int CTRL_B_RUN = 5;
   localparam int CTRL_A_CNT = 6;
   localparam int CTRL_B_CNT = 7;
   localparam int CTRL_W = 8;
   // Pending and power word field positions.
   localparam int PEND_A = 0;
   localparam int PEND_B = 1;
   localparam int PWR_IDLE = 0;
   localparam int PWR_DOWN = 1;
   // Interrupt status layout.
   localparam int EV_PEND_A = 0;
   localparam int EV_PEND_B = 1;
   localparam int EV_OVF_A = 2;
   localparam int EV_OVF_B = 3;
   localparam int EV_WAKE = 4;
   localparam int EV_W = 5;
   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [4:0] IRQ_EN_RESET = 5'h00;
   localparam logic [15:0] TIMER_RESET = 16'h0000;
   // Core clock cycles per timer tick.
   localparam int TICK_DIV = 4;
endpackage : eit_pkg

// ********************************************************************
// Pin synchroniser with falling edge detection
// ********************************************************************
module eit_pin_sync #(
   parameter int W = 4
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   // Two stages; only the second stage is read by logic. Idle high.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         meta_reg <= '1;
         sync_reg <= '1;
         prev_reg <= '1;
      end
      else
      begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // A falling edge is a high sample followed by a low one.
   assign level_o = sync_reg;
   assign fall_o = prev_reg & ~sync_reg;
endmodule : eit_pin_sync

/* File: verif/eit_chk.sv */
`timescale 1ns/100ps
// ******************************
// Port-level checker
// ******************************
module eit_chk #(
   parameter int TICK_DIV = 4
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [eit_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [eit_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [eit_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic ext_irq_a_pin_i,
   input wire logic ext_irq_b_pin_i,
   input wire logic timer_a_count_pin_i,
   input wire logic timer_b_count_pin_i,
   input wire logic usb_wake_event_i,
   input wire logic ext_irq_a_pending_o,
   input wire logic ext_irq_b_pending_o,
   input wire logic cpu_halt_o,
   input wire logic periph_clk_en_o,
   input wire logic irq_o
);
   logic [7:0] ctrl_reg;
   logic wr_done;
   logic pwr_wr;
   // A write lands at the edge where waitrequest is sampled low.
   assign wr_done = avs_write_i && !avs_waitrequest_o;
   assign pwr_wr = wr_done && avs_byteenable_i[0] && avs_address_i == eit_pkg::OFS_POWER;
   // Shadow of the control word, so the mode bits can qualify the pin checks.
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         ctrl_reg <= eit_pkg::CTRL_RESET;
      else if (wr_done && avs_byteenable_i[0] && avs_address_i == eit_pkg::OFS_CTRL)
         ctrl_reg <= avs_writedata_i[7:0];
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);
   // Every request gets exactly one wait cycle.
   wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("request did not complete after one wait cycle");
   a_edge_a: assert property (ctrl_reg[0] && $fell(ext_irq_a_pin_i) |->
      ##[1:4] ext_irq_a_pending_o)
      else $error("falling edge on pin a did not set its flag");
   a_level_a: assert property ((!ctrl_reg[0] && !ext_irq_a_pin_i) [*3] |=>
      ext_irq_a_pending_o)
      else $error("low level on pin a did not set its flag");
   b_edge_a: assert property (ctrl_reg[1] && $fell(ext_irq_b_pin_i) |->
      ##[1:4] ext_irq_b_pending_o)
      else $error("falling edge on pin b did not set its flag");
   b_level_a: assert property ((!ctrl_reg[1] && !ext_irq_b_pin_i) [*3] |=>
      ext_irq_b_pending_o)
      else $error("low level on pin b did not set its flag");
   idle_enter_a: assert property (pwr_wr && avs_writedata_i[0] |=> cpu_halt_o)
      else $error("idle write did not halt the core");
   pdown_enter_a: assert property (pwr_wr && avs_writedata_i[1] |=>
      !periph_clk_en_o && cpu_halt_o)
      else $error("power-down write did not stop the clock");
   usb_wake_a: assert property (!periph_clk_en_o && $fell(usb_wake_event_i) |->
      ##[1:6] periph_clk_en_o)
      else $error("wake edge did not restart the clock");
   // Without a synchroniser the flag could rise on the same edge the pin moves.
   sync_delay_a: assert property ($rose(ext_irq_a_pending_o) |->
      !$past(ext_irq_a_pin_i, 2) || !$past(ext_irq_a_pin_i, 3))
      else $error("flag a rose without a synchronised low pin");
   cover property ($rose(irq_o));
   cover property ($rose(periph_clk_en_o));
   cover property ($fell(cpu_halt_o));
endmodule : eit_chk

bind eit_core eit_chk #(.TICK_DIV(TICK_DIV)) u_eit_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .ext_irq_a_pin_i(ext_irq_a_pin_i), .ext_irq_b_pin_i(ext_irq_b_pin_i),
   .timer_a_count_pin_i(timer_a_count_pin_i), .timer_b_count_pin_i(timer_b_count_pin_i),
   .usb_wake_event_i(usb_wake_event_i), .ext_irq_a_pending_o(ext_irq_a_pending_o),
   .ext_irq_b_pending_o(ext_irq_b_pending_o), .cpu_halt_o(cpu_halt_o),
   .periph_clk_en_o(periph_clk_en_o), .irq_o(irq_o));

/* File: verif/eit_pin_model.sv */
`timescale 1ns/100ps
// ******************************
// External pin drivers
// ******************************
module eit_pin_model (
   input wire logic ref_clk_i,
   output logic irq_a_o,
   output logic irq_b_o,
   output logic cnt_a_o,
   output logic cnt_b_o,
   output logic wake_o
);
   logic [4:0] pin_reg = 5'h1f;
   // Pins idle high, as pull-ups hold them when nothing drives low.
   assign {wake_o, cnt_b_o, cnt_a_o, irq_b_o, irq_a_o} = pin_reg;
   task automatic hold(input int idx, input logic v);
      @(posedge ref_clk_i);
      pin_reg[idx] <= v;
   endtask : hold
   // Three clocks per phase, so the two-stage synchroniser never misses a pulse.
   task automatic pulse(input int idx, input int n);
      repeat (n)
      begin
         hold(idx, 1'b0);
         repeat (2) @(posedge ref_clk_i);
         hold(idx, 1'b1);
         repeat (2) @(posedge ref_clk_i);
      end
   endtask : pulse
endmodule : eit_pin_model

/* File: verif/testbench.sv */
`timescale 1ns/100ps
// ******************************
// Self-checking testbench
// ******************************
module testbench;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] d;
   logic wreq, pa, pb, halt, clk_en, irq, ia, ib, ca, cb, wk;
   int errors = 0;
   int check_count = 0;
   // A 100 ns period.
   always #50 ref_clk_i = ~ref_clk_i;
   eit_core #(.TICK_DIV(2)) u_eit_core (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .ext_irq_a_pin_i(ia), .ext_irq_b_pin_i(ib), .timer_a_count_pin_i(ca),
      .timer_b_count_pin_i(cb), .usb_wake_event_i(wk), .ext_irq_a_pending_o(pa),
      .ext_irq_b_pending_o(pb), .cpu_halt_o(halt), .periph_clk_en_o(clk_en), .irq_o(irq));
   eit_pin_model u_eit_pin_model (.ref_clk_i(ref_clk_i), .irq_a_o(ia), .irq_b_o(ib),
      .cnt_a_o(ca), .cnt_b_o(cb), .wake_o(wk));
   // ******************************
   // Shared tasks
   // ******************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Outputs are read just after an edge, so they hold the settled pre-edge value.
   function automatic logic [31:0] outs();
      return {27'h0, pa, pb, halt, clk_en, irq};
   endfunction : outs
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : tick
   task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] v);
      @(posedge ref_clk_i);
      adr <= a;
      wdat <= v;
      wr <= w;
      rd <= !w;
      do @(posedge ref_clk_i); while (wreq !== 1'b0);
      d = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic pin(input int i, input int n);
      u_eit_pin_model.pulse(i, n);
   endtask : pin
   // ******************************
   // Scenarios
   // ******************************
   task automatic t_reset();
      bus(eit_pkg::OFS_CTRL, 0, 0);
      chk(d, 32'h0);
      bus(eit_pkg::OFS_IRQ_ENABLE, 0, 0);
      chk(d, 32'h0);
      bus(eit_pkg::OFS_TIMER_A, 0, 0);
      chk(d, 32'h0);
      bus(6'h20, 0, 0);
      chk(d, 32'h0);
      chk(outs(), 32'h2);
   endtask : t_reset
   task automatic t_edge();
      bus(eit_pkg::OFS_CTRL, 1, 32'h3);
      pin(0, 1);
      tick(2);
      chk(outs(), 32'h12);
      pin(1, 1);
      tick(2);
      chk(outs(), 32'h1a);
      bus(eit_pkg::OFS_PEND, 1, 32'h3);
      bus(eit_pkg::OFS_PEND, 0, 0);
      chk(d, 32'h0);
   endtask : t_edge
   task automatic t_level();
      bus(eit_pkg::OFS_CTRL, 1, 32'h0);
      u_eit_pin_model.hold(0, 1'b0);
      u_eit_pin_model.hold(1, 1'b0);
      tick(4);
      bus(eit_pkg::OFS_PEND, 1, 32'h3);
      bus(eit_pkg::OFS_PEND, 0, 0);
      chk(d, 32'h3);
      u_eit_pin_model.hold(0, 1'b1);
      u_eit_pin_model.hold(1, 1'b1);
      tick(4);
      bus(eit_pkg::OFS_PEND, 1, 32'h3);
      bus(eit_pkg::OFS_PEND, 0, 0);
      chk(d, 32'h0);
   endtask : t_level
   task automatic t_gate();
      bus(eit_pkg::OFS_CTRL, 1, 32'hfc);
      u_eit_pin_model.hold(0, 1'b0);
      u_eit_pin_model.hold(1, 1'b0);
      pin(2, 2);
      pin(3, 2);
      bus(eit_pkg::OFS_TIMER_A, 0, 0);
      chk(d, 32'h0);
      bus(eit_pkg::OFS_TIMER_B, 0, 0);
      chk(d, 32'h0);
      u_eit_pin_model.hold(0, 1'b1);
      u_eit_pin_model.hold(1, 1'b1);
      pin(2, 3);
      pin(3, 5);
      bus(eit_pkg::OFS_TIMER_A, 0, 0);
      chk(d, 32'h3);
      bus(eit_pkg::OFS_TIMER_B, 0, 0);
      chk(d, 32'h5);
      bus(eit_pkg::OFS_PEND, 1, 32'h3);
      // Timer mode: B wraps from all ones, so it must end small and flag an overflow.
      bus(eit_pkg::OFS_TIMER_B, 1, 32'hffff);
      bus(eit_pkg::OFS_CTRL, 1, 32'h20);
      tick(4);
      bus(eit_pkg::OFS_CTRL, 1, 32'h0);
      bus(eit_pkg::OFS_TIMER_B, 0, 0);
      chk(d & 32'hfff8, 32'h0);
      bus(eit_pkg::OFS_IRQ_STATUS, 0, 0);
      chk(d & 32'h8, 32'h8);
   endtask : t_gate
   task automatic t_irq();
      bus(eit_pkg::OFS_IRQ_CLEAR, 1, 32'h1f);
      bus(eit_pkg::OFS_IRQ_ENABLE, 1, 32'h1);
      bus(eit_pkg::OFS_CTRL, 1, 32'h3);
      pin(0, 1);
      tick(2);
      chk({31'h0, irq}, 32'h1);
      bus(eit_pkg::OFS_PEND, 1, 32'h1);
      bus(eit_pkg::OFS_IRQ_CLEAR, 1, 32'h1);
      tick(1);
      chk({31'h0, irq}, 32'h0);
      bus(eit_pkg::OFS_IRQ_ENABLE, 1, 32'h0);
      pin(1, 1);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      bus(eit_pkg::OFS_IRQ_STATUS, 0, 0);
      chk(d & 32'h2, 32'h2);
      bus(eit_pkg::OFS_IRQ_CLEAR, 0, 0);
      chk(d, 32'h0);
      bus(eit_pkg::OFS_PEND, 1, 32'h3);
      bus(eit_pkg::OFS_IRQ_CLEAR, 1, 32'h1f);
   endtask : t_irq
   task automatic t_power();
      bus(eit_pkg::OFS_CTRL, 1, 32'h53);
      bus(eit_pkg::OFS_TIMER_A, 1, 32'h0);
      bus(eit_pkg::OFS_POWER, 1, 32'h1);
      tick(1);
      chk(outs(), 32'h6);
      pin(2, 2);
      bus(eit_pkg::OFS_TIMER_A, 0, 0);
      chk(d, 32'h2);
      pin(0, 1);
      tick(2);
      chk({31'h0, halt}, 32'h0);
      bus(eit_pkg::OFS_PEND, 1, 32'h3);
      bus(eit_pkg::OFS_POWER, 1, 32'h2);
      tick(1);
      chk(outs(), 32'h4);
      pin(2, 2);
      pin(4, 1);
      tick(2);
      chk(outs(), 32'h2);
      bus(eit_pkg::OFS_TIMER_A, 0, 0);
      chk(d, 32'h2);
      bus(eit_pkg::OFS_IRQ_STATUS, 0, 0);
      chk(d & 32'h10, 32'h10);
      bus(eit_pkg::OFS_POWER, 1, 32'h2);
      pin(1, 1);
      tick(2);
      chk({31'h0, clk_en}, 32'h1);
   endtask : t_power
   task automatic summarize();
      if (errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   // Main sequence after five cycles of reset.
   initial
   begin
      tick(5);
      reset_i <= 1'b0;
      t_reset();
      t_edge();
      t_level();
      t_gate();
      t_irq();
      t_power();
      summarize();
   end
   // The scenarios need under 2000 cycles; a hang ends the run here.
   initial
   begin
      tick(8000);
      errors++;
      summarize();
   end
endmodule : testbench
